// ===== dv/qbt_bus_model.sv
// Purpose: other open-collector parties on the shared bus
// Assumes: a pull-up holds every idle line high
// Notes:   pull-low only, so a shared line needs no tri-state
module qbt_bus_model
   import qbt_pkg::*;
(
   // pull-low enables of both sides
   input  wire qbt_pkg::qbt_word_t i_dut_oe,
   input  wire qbt_pkg::qbt_word_t i_other_oe,
   // resolved lines
   output qbt_pkg::qbt_word_t o_line
);
   timeunit 1ns;
   timeprecision 100ps;
   // any party pulling low wins over the pull-up
   assign o_line = ~(i_dut_oe | i_other_oe);
endmodule

// ===== dv/qbt_transceiver_tb.sv
// Purpose: self-checking bench of the quad bus transceiver
// Assumes: inputs change 1 ns after the rising clock edge
// Notes:   outputs are registered except o_bus_oe on drive enable; checks follow one edge later
module qbt_transceiver_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import qbt_pkg::*;
   logic      clk = 1'h0, sys_rst = 1'h1, sel = 1'h0, drc = 1'h0;
   logic      be_n = 1'h1, rle_n = 1'h0, rx_ready = 1'h1;
   qbt_word_t first = 4'h0, second = 4'h0, other_oe = 4'h0;
   qbt_word_t bus_line, bus_oe, bus_drv, rcv, rx_data;
   logic      par, rx_valid, fifo_rdy;
   int        errors = 0;
   int        total_checks = 0;

   always #50 clk = ~clk;

   qbt_transceiver dut_u (.i_clk(clk), .i_sys_rst(sys_rst),
      .i_first_word_in(first), .i_second_word_in(second),
      .i_word_select(sel), .i_driver_register_clock(drc),
      .i_bus_drive_enable_n(be_n), .i_bus_line(bus_line),
      .o_bus_line(bus_drv), .o_bus_oe(bus_oe),
      .i_receiver_latch_enable_n(rle_n), .o_receiver_out(rcv),
      .o_odd_parity(par), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
      .i_rx_ready(rx_ready), .o_rx_fifo_ready(fifo_rdy));

   qbt_bus_model bus_u (.i_dut_oe(bus_oe), .i_other_oe(other_oe),
      .o_line(bus_line));

   task step;
      @(posedge clk);
      #1;
   endtask

   task check(string n, qbt_word_t e, qbt_word_t g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   task print_verdict;
      if (errors == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // pin low one cycle, then high: one rise seen on the system clock
   task load(logic s, qbt_word_t a, qbt_word_t b);
      drc = 1'h0;
      sel = s;
      first = a;
      second = b;
      step;
      drc = 1'h1;
      step;
   endtask

   task t_load;
      qbt_word_t w;
      be_n = 1'h0;
      for (int i = 0; i < 16; i++) begin
         w = i[0] ? ~i[3:0] : i[3:0];
         load(i[0], i[3:0], ~i[3:0]);
         check("bus_oe", w, bus_oe);
         check("bus_line", ~w, bus_line);
         check("bus_drv", 4'h0, bus_drv);
         step;
         check("receiver", w, rcv);
      end
   endtask

   task t_hold;
      load(1'h0, 4'h9, 4'h6);
      first = 4'h2;
      sel = 1'h1;
      repeat (3) step;
      check("held_high", 4'h9, bus_oe);
      drc = 1'h0;
      repeat (3) step;
      check("held_low", 4'h9, bus_oe);
      be_n = 1'h1;
      step;
      check("released", 4'h0, bus_oe);
      check("idle_bus", 4'hf, bus_line);
   endtask

   task t_pgen;
      logic p;
      be_n = 1'h0;
      for (int i = 0; i < 16; i++) begin
         sel = i[0];
         first = i[3:0];
         second = i[3:0] ^ 4'h1;
         p = i[0] ? ^second : ^first;
         step;
         check("gen_parity", p, par);
      end
   endtask

   // register still holds 9 here
   task t_rx;
      other_oe = 4'h4;
      step;
      check("wired_or", 4'hd, rcv);
      be_n = 1'h1;
      other_oe = 4'h7;
      step;
      check("rx_open", 4'h7, rcv);
      rle_n = 1'h1;
      step;
      other_oe = 4'h3;
      repeat (2) step;
      check("rx_held", 4'h7, rcv);
      check("chk_parity", 4'h1, par);
   endtask

   // nine closes into eight places: the last word must be dropped
   task t_fifo;
      rx_ready = 1'h0;
      for (int k = 1; k < 10; k++) begin
         rle_n = 1'h0;
         other_oe = k[3:0];
         step;
         rle_n = 1'h1;
         step;
      end
      check("fifo_ready", 4'h0, fifo_rdy);
      rx_ready = 1'h1;
      for (int k = 1; k < 9; k++) begin
         check("rx_valid", 4'h1, rx_valid);
         check("rx_data", k[3:0], rx_data);
         step;
      end
      check("rx_empty", 4'h0, rx_valid);
   endtask

   initial begin
      repeat (8) @(posedge clk);
      check("reset_oe", 4'h0, bus_oe);
      #1;
      sys_rst = 1'h0;
      t_load;
      t_hold;
      t_pgen;
      t_rx;
      t_fifo;
      print_verdict;
   end

   // the run needs about 112 cycles; allow nearly eighteen times that
   initial begin
      #200000;
      errors++;
      print_verdict;
   end
endmodule

// ===== verilog/qbt_params.svh
// Purpose: constants of the quad bus transceiver with parity
// Assumes: included by the package and the design file
// Notes:   definitions only
`ifndef QBT_PARAMS_SVH
`define QBT_PARAMS_SVH

`define QBT_WORD_W       4
`define QBT_FIFO_DEPTH   8
`define QBT_WORD_RST     4'h0
`define QBT_BIT_RST      1'b0
`define QBT_EDGE_HIST_RST 1'b1
`define QBT_SEL_FIRST    1'b0
`define QBT_SEL_SECOND   1'b1
`define QBT_BUS_PULL_LVL 1'b0
`define QBT_CLK_PERIOD_NS 100

`endif

// ===== verilog/qbt_pkg.sv
// Purpose: shared types of the quad bus transceiver with parity
// Assumes: qbt_params.svh supplies the widths
// Notes:   one word type for all four-bit paths
`include "qbt_params.svh"

package qbt_pkg;
   typedef logic [`QBT_WORD_W-1:0] qbt_word_t;
endpackage

// ===== verilog/qbt_transceiver.sv
// Purpose: four-bit registered bus transceiver, open-collector bus,
//          receive latches, odd parity generate/check, receive FIFO
// Assumes: all inputs synchronous to i_clk (10 MHz); the bus lines
//          are resolved outside with a pull-up
// Notes:   driver clock and latch enable are sampled pins, edges are
//          found against i_clk; registered outputs lag their cause by one cycle, o_bus_oe follows drive enable at once
`include "qbt_params.svh"

module qbt_fifo #(
   parameter int WIDTH = `QBT_WORD_W,
   parameter int DEPTH = `QBT_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_sys_rst,
   // filling side
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_in_ready,
   // draining side
   output logic                  o_out_valid,
   output logic [WIDTH-1:0]      o_out_data,
   input  wire logic             i_out_ready,
   output logic                  o_full,
   output logic                  o_empty
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [CW-1:0]    count;
   logic             push;
   logic             pop;

   assign o_full      = (count == CW'(DEPTH));
   assign o_empty     = (count == '0);
   assign o_in_ready  = !o_full;
   assign o_out_valid = !o_empty;
   assign o_out_data  = mem[rd_ptr];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         count <= '0;
      end else if (push && !pop) begin
         count <= count + 1'b1;
      end else if (pop && !push) begin
         count <= count - 1'b1;
      end
   end

   default clocking fifo_cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   // a full queue must neither grow nor disturb its head word
   fifo_full_a : assert property (o_full && !i_out_ready
                                  |=> o_full && $stable(o_out_data))
      else $error("fifo accepts while full");
   fifo_count_a : assert property (push && !pop
                                   |=> count == $past(count) + 1'b1)
      else $error("fifo count did not grow on push");
   fifo_drain_a : assert property (pop && !push
                                   |=> count == $past(count) - 1'b1)
      else $error("fifo count did not shrink on pop");
   fifo_bound_a : assert property (count <= CW'(DEPTH))
      else $error("fifo count beyond its depth");
endmodule

// Behaviour
// - load selected word on driver clock rise
// - register holds while driver clock steady
// - select low loads first, high second
// - drive enable high releases all bus lines
// - enabled line carries inverse of register bit
// - open-collector drivers, shared wired bus
// - receiver presents inverse of bus line
// - latch enable low: latches follow bus
// - latch enable high: latches hold data
// - drive enabled: parity over selected input word
// - drive disabled: parity over latch outputs
// - parity is exclusive-OR of four bits
module qbt_transceiver
   import qbt_pkg::*;
#(
   parameter int FIFO_DEPTH = `QBT_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic          i_clk,
   input  wire logic          i_sys_rst,
   // driver side inputs
   input  wire qbt_pkg::qbt_word_t i_first_word_in,
   input  wire qbt_pkg::qbt_word_t i_second_word_in,
   input  wire logic          i_word_select,
   input  wire logic          i_driver_register_clock,
   input  wire logic          i_bus_drive_enable_n,
   // open-collector bus lines
   input  wire qbt_pkg::qbt_word_t i_bus_line,
   output qbt_pkg::qbt_word_t o_bus_line,
   output qbt_pkg::qbt_word_t o_bus_oe,
   // receiver side
   input  wire logic          i_receiver_latch_enable_n,
   output qbt_pkg::qbt_word_t o_receiver_out,
   output logic               o_odd_parity,
   // received word stream
   output logic               o_rx_valid,
   output qbt_pkg::qbt_word_t o_rx_data,
   input  wire logic          i_rx_ready,
   output logic               o_rx_fifo_ready
);
   import qbt_pkg::*;

   qbt_word_t driver_q;
   qbt_word_t latch_state;
   qbt_word_t selected_word;
   logic      driver_register_clock_prev;
   logic      rle_prev;
   logic      driver_register_clock_rise;
   logic      latch_close;
   logic      next_parity;

   assign driver_register_clock_rise   = i_driver_register_clock && !driver_register_clock_prev;
   assign latch_close = i_receiver_latch_enable_n && !rle_prev;

   // one mux select for all four bits
   assign selected_word = (i_word_select == `QBT_SEL_SECOND)
                          ? i_second_word_in : i_first_word_in;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         // history starts high: a pin already high after reset is no edge
         driver_register_clock_prev <= `QBT_EDGE_HIST_RST;
         rle_prev  <= `QBT_EDGE_HIST_RST;
      end else begin
         driver_register_clock_prev <= i_driver_register_clock;
         rle_prev  <= i_receiver_latch_enable_n;
      end
   end

   // a steady driver clock, high or low, leaves the register alone
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         driver_q <= `QBT_WORD_RST;
      end else if (driver_register_clock_rise) begin
         driver_q <= selected_word;
      end
   end

   // never drive high: a one in the register sinks the line, a zero
   // lets the external pull-up raise it, so wired sharing stays safe
   assign o_bus_line = {`QBT_WORD_W{`QBT_BUS_PULL_LVL}};
   assign o_bus_oe   = i_bus_drive_enable_n ? `QBT_WORD_RST
                       : driver_q;

   // the latch is a flop loaded every cycle while open, so the output
   // trails the bus by one clock; glitch-free trade for transparency
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         latch_state <= `QBT_WORD_RST;
      end else if (!i_receiver_latch_enable_n) begin
         latch_state <= ~i_bus_line;
      end
   end

   assign o_receiver_out = latch_state;

   always_comb begin
      if (!i_bus_drive_enable_n) begin
         next_parity = ^selected_word;
      end else begin
         next_parity = ^latch_state;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_odd_parity <= `QBT_BIT_RST;
      end else begin
         o_odd_parity <= next_parity;
      end
   end

   // each closed latch word is queued; a full queue drops the word,
   // which o_rx_fifo_ready low warns of ahead of the close
   qbt_fifo #(
      .WIDTH (`QBT_WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .i_clk       (i_clk),
      .i_sys_rst   (i_sys_rst),
      .i_in_valid  (latch_close),
      .i_in_data   (latch_state),
      .o_in_ready  (o_rx_fifo_ready),
      .o_out_valid (o_rx_valid),
      .o_out_data  (o_rx_data),
      .i_out_ready (i_rx_ready),
      .o_full      (),
      .o_empty     ()
   );

   default clocking top_cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   sequence driver_register_clock_rise_s;
      !i_driver_register_clock ##1 i_driver_register_clock;
   endsequence

   sequence latch_closed_s;
      !i_receiver_latch_enable_n ##1 i_receiver_latch_enable_n[*2];
   endsequence

   property load_p;
      driver_register_clock_rise |=> driver_q == $past(selected_word);
   endproperty

   drv_load_a : assert property (load_p)
      else $error("driver register missed a clock rise");
   drv_hold_a : assert property (!driver_register_clock_rise |=> $stable(driver_q))
      else $error("driver register changed without a clock rise");
   sequence driver_register_clock_high_s;
      i_driver_register_clock[*2];
   endsequence

   sequence driver_register_clock_load_en_s;
      driver_register_clock_rise_s ##1 !i_bus_drive_enable_n;
   endsequence

   sequence rx_close_s;
      !i_receiver_latch_enable_n ##1 i_receiver_latch_enable_n;
   endsequence

   property rx_follow_p;
      !i_receiver_latch_enable_n |=> o_receiver_out == ~$past(i_bus_line);
   endproperty

   property gen_first_p;
      !i_bus_drive_enable_n && !i_word_select
      |=> o_odd_parity == ^$past(i_first_word_in);
   endproperty

   property gen_second_p;
      !i_bus_drive_enable_n && i_word_select
      |=> o_odd_parity == ^$past(i_second_word_in);
   endproperty

   property check_p;
      i_bus_drive_enable_n |=> o_odd_parity == ^$past(o_receiver_out);
   endproperty

   // a clock parked high must not look like a fresh rise
   drv_hi_a : assert property (driver_register_clock_high_s |=> $stable(driver_q))
      else $error("driver register changed with clock held high");
   drv_low_a : assert property (!i_driver_register_clock
                                |=> $stable(driver_q))
      else $error("driver register changed with clock held low");
   sel_first_a : assert property (driver_register_clock_rise_s ##0 !i_word_select
                                  |=> driver_q == $past(i_first_word_in))
      else $error("select low did not load first word");
   sel_second_a : assert property (driver_register_clock_rise_s ##0 i_word_select
                                   |=> driver_q == $past(i_second_word_in))
      else $error("select high did not load second word");
   bus_release_a : assert property (i_bus_drive_enable_n
                                    |-> o_bus_oe == '0)
      else $error("bus driven while drive enable high");
   bus_drive_a : assert property (!i_bus_drive_enable_n
                                  |-> o_bus_oe == driver_q)
      else $error("bus pulls do not match register");
   bus_load_a : assert property (driver_register_clock_load_en_s
      |-> o_bus_oe == ($past(i_word_select) ? $past(i_second_word_in)
                                            : $past(i_first_word_in)))
      else $error("bus pulls do not show the loaded word");
   pull_only_a : assert property (o_bus_line == '0)
      else $error("bus line driven high");
   rx_follow_a : assert property (rx_follow_p)
      else $error("open latch does not follow inverted bus");
   rx_hold_a : assert property (latch_closed_s
                                |-> $stable(latch_state))
      else $error("closed latch changed");
   rx_frozen_a : assert property (i_receiver_latch_enable_n
                                  |=> $stable(o_receiver_out))
      else $error("receiver output moved while latch closed");
   rx_push_a : assert property (rx_close_s ##0 !o_rx_valid
      |=> o_rx_valid && o_rx_data == $past(latch_state))
      else $error("closed word not queued");
   parity_gen_a : assert property (gen_first_p)
      else $error("generated parity wrong");
   parity_second_a : assert property (gen_second_p)
      else $error("generated parity of second word wrong");
   parity_chk_a : assert property (check_p)
      else $error("checked parity wrong");
endmodule
